// File: design/i2c_rd_pkg.sv
// Purpose: Shared constants and types of the bus read engine
// Assumes: System clock of 250 MHz
// Notes: Bit times are the least bit periods of the two bus speeds
package i2c_rd_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int BIT_FAST_NS = 2500;
  localparam int BIT_SLOW_NS = 10000;
  localparam int QTR_FAST_CYC = (BIT_FAST_NS * CLK_MHZ + 3999) / 4000;
  localparam int QTR_SLOW_CYC = (BIT_SLOW_NS * CLK_MHZ + 3999) / 4000;
  localparam int DIV_W = 10;
  localparam logic [DIV_W-1:0] DIV_FAST = DIV_W'(QTR_FAST_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_SLOW = DIV_W'(QTR_SLOW_CYC - 1);

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  localparam logic [1:0] ADDR_NONE = 2'h0;
  localparam logic [1:0] ADDR_8 = 2'h1;
  localparam logic [1:0] ADDR_16 = 2'h2;
  localparam logic [1:0] KIND_BIT = 2'h0;
  localparam logic [1:0] KIND_BYTE = 2'h1;
  localparam logic [1:0] KIND_WORD = 2'h2;
  localparam logic [1:0] KIND_ARRAY = 2'h3;
  localparam logic [1:0] TX_CTRL_W = 2'h0;
  localparam logic [1:0] TX_ADDR_HI = 2'h1;
  localparam logic [1:0] TX_ADDR_LO = 2'h2;
  localparam logic [1:0] TX_CTRL_R = 2'h3;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [1:0] Q_LOW = 2'h0;
  localparam logic [1:0] Q_RISE = 2'h1;
  localparam logic [1:0] Q_HIGH = 2'h2;
  localparam logic [1:0] Q_FALL = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_TX = 3'h3,
    ST_RSTART = 3'h2,
    ST_RX = 3'h6,
    ST_STOP = 3'h7
  } state_type;
endpackage

// File: design/rd_fifo.sv
// Purpose: Small FIFO with registered read data
// Assumes: DEPTH is a power of two
// Notes: Show-ahead output register
`timescale 1ns/1ps
module rd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("rd_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [WIDTH-1:0] out_data;
    logic out_valid;
  } fifo_state_type;

  fifo_state_type r_reg;
  fifo_state_type r_next;
  logic [AW:0] fill;

  assign fill = r_reg.wp - r_reg.rp;
  assign o_in_ready = (fill != (AW + 1)'(DEPTH));
  assign o_out_valid = r_reg.out_valid;
  assign o_out_data = r_reg.out_data;

  always_comb begin
    r_next = r_reg;
    if (i_in_valid && o_in_ready) begin
      r_next.mem[r_reg.wp[AW-1:0]] = i_in_data;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (!r_reg.out_valid || i_out_ready) begin
      if (fill != '0) begin
        r_next.out_data = r_reg.mem[r_reg.rp[AW-1:0]];
        r_next.out_valid = 1'b1;
        r_next.rp = r_reg.rp + 1'b1;
      end else begin
        r_next.out_valid = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule

// File: design/i2c_read_engine.sv
// Purpose: Two-wire bus master that reads items from a slave
// Assumes: Open-drain lines with external pull-ups
// Notes: Read items are queued in a FIFO toward the user
//
// Contract
// - Control byte: address in top seven, bit0 direction
// - Read control byte always has bit0 forced high
// - Optional 8 or 16 bit internal address
// - Items read in order, byte 8, word 16
// - Bit item still consumes a whole byte
// - Data line released after transfer and while idle
// - Master drives the clock for whole transfer
// - Array filled fully unless count given
// - Both sides drive lines only low, except the clock driven high with the driven-clock option
// - Slow option lowers bus to standard rate
// - Driven-clock option drives clock high and low
`timescale 1ns/1ps
module i2c_read_engine #(
  parameter int ARRAY_LEN = 10,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Command
  input wire logic i_bus_read_command,
  input wire logic [7:0] i_ctrl,
  input wire logic [1:0] i_addr_mode,
  input wire logic [15:0] i_addr,
  input wire logic [1:0] i_item_kind,
  input wire logic [7:0] i_item_count,
  input wire logic i_array_length_modifier,
  // Options
  input wire logic i_slow_bus,
  input wire logic i_drive_scl,
  // Status
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  // Read data stream
  output logic o_rd_valid,
  output logic [15:0] o_rd_data,
  input wire logic i_rd_ready,
  // Bus pins
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe
);
  initial begin
    if (ARRAY_LEN < 1 || ARRAY_LEN > 255) begin
      $error("i2c_read_engine: ARRAY_LEN must be 1 to 255");
    end
  end

  typedef struct packed {
    i2c_rd_pkg::state_type st;
    logic [1:0] q;
    logic [i2c_rd_pkg::DIV_W-1:0] div;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic [1:0] tx_sel;
    logic [7:0] rd_ctrl;
    logic [15:0] addr;
    logic [1:0] amode;
    logic [1:0] kind;
    logic [7:0] left;
    logic half;
    logic final_byte;
    logic [15:0] word;
    logic item_full;
    logic sda_low;
    logic scl_low;
    logic done;
    logic nack;
    logic sda_s1;
    logic sda_s2;
    logic scl_s1;
    logic scl_s2;
  } eng_state_type;

  eng_state_type r_reg;
  eng_state_type r_next;
  logic tick;
  logic adv;
  logic push_ready;
  logic [7:0] req_len;

  // ------------------------------------------------------------
  // Pins and status
  // ------------------------------------------------------------
  assign o_busy = (r_reg.st != i2c_rd_pkg::ST_IDLE);
  assign o_done = r_reg.done;
  assign o_nack = r_reg.nack;
  assign o_sda_out = 1'b0;
  assign o_sda_oe = r_reg.sda_low;
  assign o_scl_out = i_drive_scl & ~r_reg.scl_low;
  assign o_scl_oe = i_drive_scl ? o_busy : r_reg.scl_low;

  assign req_len = (i_item_kind == i2c_rd_pkg::KIND_ARRAY && !i_array_length_modifier) ?
                   8'(ARRAY_LEN) : i_item_count;
  assign tick = (r_reg.div == '0);
  assign adv = tick && o_busy
               && !(r_reg.q == i2c_rd_pkg::Q_HIGH && !r_reg.scl_s2)
               && !(r_reg.st == i2c_rd_pkg::ST_RX && r_reg.q == i2c_rd_pkg::Q_LOW
                    && r_reg.bitn == 4'h0 && r_reg.item_full)
               && !(r_reg.st == i2c_rd_pkg::ST_STOP && r_reg.q == i2c_rd_pkg::Q_FALL
                    && r_reg.item_full);

  // ------------------------------------------------------------
  // Engine
  // ------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.sda_s1 = i_sda;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.scl_s1 = i_scl;
    r_next.scl_s2 = r_reg.scl_s1;
    if (r_reg.item_full && push_ready) begin
      r_next.item_full = 1'b0;
    end
    if (o_busy) begin
      r_next.div = tick ? (i_slow_bus ? i2c_rd_pkg::DIV_SLOW : i2c_rd_pkg::DIV_FAST)
                        : r_reg.div - 1'b1;
    end
    if (adv) begin
      r_next.q = r_reg.q + 1'b1;
    end
    unique case (r_reg.st)
      i2c_rd_pkg::ST_IDLE: begin
        r_next.sda_low = 1'b0;
        r_next.scl_low = 1'b0;
        r_next.div = '0;
        r_next.q = i2c_rd_pkg::Q_LOW;
        if (i_bus_read_command && req_len != 8'h00) begin
          r_next.st = i2c_rd_pkg::ST_START;
          r_next.rd_ctrl = {i_ctrl[7:1], 1'b1};
          r_next.addr = i_addr;
          r_next.amode = i_addr_mode;
          r_next.kind = i_item_kind;
          r_next.left = req_len;
          r_next.half = 1'b0;
          r_next.nack = 1'b0;
        end
      end
      i2c_rd_pkg::ST_START: begin
        if (adv) begin
          unique case (r_reg.q)
            i2c_rd_pkg::Q_RISE: r_next.sda_low = 1'b1;
            i2c_rd_pkg::Q_FALL: begin
              r_next.scl_low = 1'b1;
              r_next.st = i2c_rd_pkg::ST_TX;
              r_next.bitn = 4'h0;
              if (r_reg.amode == i2c_rd_pkg::ADDR_NONE) begin
                r_next.tx_sel = i2c_rd_pkg::TX_CTRL_R;
                r_next.shift = r_reg.rd_ctrl;
              end else begin
                r_next.tx_sel = i2c_rd_pkg::TX_CTRL_W;
                r_next.shift = {r_reg.rd_ctrl[7:1], 1'b0};
              end
            end
            default: ;
          endcase
        end
      end
      i2c_rd_pkg::ST_TX: begin
        if (adv) begin
          unique case (r_reg.q)
            i2c_rd_pkg::Q_LOW:
              r_next.sda_low = (r_reg.bitn == i2c_rd_pkg::ACK_BIT) ? 1'b0 : ~r_reg.shift[7];
            i2c_rd_pkg::Q_RISE: r_next.scl_low = 1'b0;
            i2c_rd_pkg::Q_HIGH:
              if (r_reg.bitn == i2c_rd_pkg::ACK_BIT) r_next.nack = r_reg.sda_s2;
            i2c_rd_pkg::Q_FALL: begin
              r_next.scl_low = 1'b1;
              if (r_reg.bitn != i2c_rd_pkg::ACK_BIT) begin
                r_next.shift = {r_reg.shift[6:0], 1'b0};
                r_next.bitn = r_reg.bitn + 1'b1;
              end else begin
                r_next.bitn = 4'h0;
                if (r_reg.nack) begin
                  r_next.st = i2c_rd_pkg::ST_STOP;
                end else begin
                  unique case (r_reg.tx_sel)
                    i2c_rd_pkg::TX_CTRL_W: begin
                      if (r_reg.amode == i2c_rd_pkg::ADDR_16) begin
                        r_next.tx_sel = i2c_rd_pkg::TX_ADDR_HI;
                        r_next.shift = r_reg.addr[15:8];
                      end else begin
                        r_next.tx_sel = i2c_rd_pkg::TX_ADDR_LO;
                        r_next.shift = r_reg.addr[7:0];
                      end
                    end
                    i2c_rd_pkg::TX_ADDR_HI: begin
                      r_next.tx_sel = i2c_rd_pkg::TX_ADDR_LO;
                      r_next.shift = r_reg.addr[7:0];
                    end
                    i2c_rd_pkg::TX_ADDR_LO: r_next.st = i2c_rd_pkg::ST_RSTART;
                    i2c_rd_pkg::TX_CTRL_R: r_next.st = i2c_rd_pkg::ST_RX;
                  endcase
                end
              end
            end
          endcase
        end
      end
      i2c_rd_pkg::ST_RSTART: begin
        if (adv) begin
          unique case (r_reg.q)
            i2c_rd_pkg::Q_LOW: r_next.sda_low = 1'b0;
            i2c_rd_pkg::Q_RISE: r_next.scl_low = 1'b0;
            i2c_rd_pkg::Q_HIGH: r_next.sda_low = 1'b1;
            i2c_rd_pkg::Q_FALL: begin
              r_next.scl_low = 1'b1;
              r_next.st = i2c_rd_pkg::ST_TX;
              r_next.tx_sel = i2c_rd_pkg::TX_CTRL_R;
              r_next.shift = r_reg.rd_ctrl;
              r_next.bitn = 4'h0;
            end
          endcase
        end
      end
      i2c_rd_pkg::ST_RX: begin
        if (adv) begin
          unique case (r_reg.q)
            i2c_rd_pkg::Q_LOW:
              r_next.sda_low = (r_reg.bitn == i2c_rd_pkg::ACK_BIT) && !r_reg.final_byte;
            i2c_rd_pkg::Q_RISE: r_next.scl_low = 1'b0;
            i2c_rd_pkg::Q_HIGH:
              if (r_reg.bitn != i2c_rd_pkg::ACK_BIT) r_next.shift = {r_reg.shift[6:0], r_reg.sda_s2};
            i2c_rd_pkg::Q_FALL: begin
              r_next.scl_low = 1'b1;
              if (r_reg.bitn == i2c_rd_pkg::ACK_BIT) begin
                r_next.bitn = 4'h0;
                if (r_reg.final_byte) r_next.st = i2c_rd_pkg::ST_STOP;
              end else begin
                r_next.bitn = r_reg.bitn + 1'b1;
              end
              if (r_reg.bitn == i2c_rd_pkg::LAST_DATA_BIT) begin
                r_next.final_byte = (r_reg.left == 8'h01)
                                    && (r_reg.kind != i2c_rd_pkg::KIND_WORD || r_reg.half);
                if (r_reg.kind == i2c_rd_pkg::KIND_WORD && !r_reg.half) begin
                  r_next.word = {r_reg.shift, 8'h00};
                  r_next.half = 1'b1;
                end else begin
                  unique case (r_reg.kind)
                    i2c_rd_pkg::KIND_WORD: r_next.word = {r_reg.word[15:8], r_reg.shift};
                    i2c_rd_pkg::KIND_BIT: r_next.word = {15'h0000, r_reg.shift[0]};
                    default: r_next.word = {8'h00, r_reg.shift};
                  endcase
                  r_next.half = 1'b0;
                  r_next.item_full = 1'b1;
                  r_next.left = r_reg.left - 1'b1;
                end
              end
            end
          endcase
        end
      end
      i2c_rd_pkg::ST_STOP: begin
        if (adv) begin
          unique case (r_reg.q)
            i2c_rd_pkg::Q_LOW: r_next.sda_low = 1'b1;
            i2c_rd_pkg::Q_RISE: r_next.scl_low = 1'b0;
            i2c_rd_pkg::Q_HIGH: r_next.sda_low = 1'b0;
            i2c_rd_pkg::Q_FALL: begin
              r_next.st = i2c_rd_pkg::ST_IDLE;
              r_next.done = 1'b1;
            end
          endcase
        end
      end
      default: r_next.st = i2c_rd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ------------------------------------------------------------
  // Output FIFO
  // ------------------------------------------------------------
  rd_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_in_valid(r_reg.item_full),
    .i_in_data(r_reg.word),
    .o_in_ready(push_ready),
    .o_out_valid(o_rd_valid),
    .o_out_data(o_rd_data),
    .i_out_ready(i_rd_ready)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_accept;
    !o_busy && i_bus_read_command && req_len != 8'h00;
  endsequence
  sequence s_ack_slot;
    r_reg.st == i2c_rd_pkg::ST_RX && r_reg.bitn == i2c_rd_pkg::ACK_BIT
    && r_reg.q == i2c_rd_pkg::Q_RISE;
  endsequence

  property p_read_dir;
    s_accept |=> r_reg.rd_ctrl[0] && r_reg.rd_ctrl[7:1] == $past(i_ctrl[7:1]);
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("read direction bit not set");

  property p_write_first;
    r_reg.st == i2c_rd_pkg::ST_START && r_next.st == i2c_rd_pkg::ST_TX
    |=> r_reg.shift[0] == (r_reg.amode == i2c_rd_pkg::ADDR_NONE);
  endproperty
  a_write_first: assert property (p_write_first) else $error("bad first control byte");

  property p_sda_low_only;
    o_sda_out == 1'b0 && (i_drive_scl || !o_scl_out);
  endproperty
  a_sda_low_only: assert property (p_sda_low_only) else $error("line driven high");

  property p_sda_idle;
    !o_busy |-> !o_sda_oe;
  endproperty
  a_sda_idle: assert property (p_sda_idle) else $error("data line held when idle");

  property p_scl_drive;
    r_reg.scl_low |-> o_scl_oe && !o_scl_out;
  endproperty
  a_scl_drive: assert property (p_scl_drive) else $error("clock not driven low");

  property p_scl_push;
    i_drive_scl && o_busy && r_reg.q == i2c_rd_pkg::Q_HIGH |-> o_scl_oe && o_scl_out;
  endproperty
  a_scl_push: assert property (p_scl_push) else $error("clock not driven in push mode");

  property p_master_ack;
    s_ack_slot |-> o_sda_oe == !r_reg.final_byte;
  endproperty
  a_master_ack: assert property (p_master_ack) else $error("wrong acknowledge level");

  property p_stop_after_last;
    r_reg.st == i2c_rd_pkg::ST_RX && r_reg.bitn == i2c_rd_pkg::ACK_BIT && r_reg.final_byte
    && r_reg.q == i2c_rd_pkg::Q_FALL && adv |=> r_reg.st == i2c_rd_pkg::ST_STOP;
  endproperty
  a_stop_after_last: assert property (p_stop_after_last) else $error("no stop after last");

  property p_slow_rate;
    tick && o_busy && i_slow_bus |=> r_reg.div == i2c_rd_pkg::DIV_SLOW;
  endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("slow divider not loaded");

  property p_done_pulse;
    o_done |=> !o_done && !o_busy;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");
endmodule

// File: sim/i2c_slave_model.sv
// Purpose: Behavioural two-wire slave with an auto-increment pointer
// Assumes: Both lines pulled up; the slave never stretches the clock
// Notes: Read data is pointer low byte xor a5, then the pointer steps
`timescale 1ns/1ps
module i2c_slave_model (
  // Bus lines
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_low
);
  // ------------------------------------------------------------
  // Bus follower
  // ------------------------------------------------------------
  logic [7:0] rx_log[$];
  logic ack_log[$];
  int starts = 0;
  int stops = 0;
  int bitc = 0;
  logic [15:0] ptr = 16'h0000;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx_byte = 8'h00;
  logic first = 1'b0;
  logic go = 1'b0;
  logic tx = 1'b0;
  logic mack = 1'b0;
  initial o_sda_low = 1'b0;
  always @(negedge i_sda) begin
    if (i_scl === 1'b1) begin
      starts++;
      bitc = 0;
      first = 1'b1;
      go = 1'b0;
      tx = 1'b0;
      mack = 1'b0;
    end
  end
  always @(posedge i_sda) begin
    if (i_scl === 1'b1) begin
      stops++;
    end
  end
  always @(posedge i_scl) begin
    if (bitc < 8) begin
      sh = {sh[6:0], i_sda};
    end else if (tx) begin
      mack = i_sda;
      ack_log.push_back(i_sda);
    end
    bitc++;
  end
  always @(negedge i_scl) begin
    if (bitc == 8 && tx) begin
      o_sda_low = 1'b0;
    end else if (bitc == 8) begin
      rx_log.push_back(sh);
      if (first) begin
        go = sh[0];
      end else begin
        ptr = {ptr[7:0], sh};
      end
      first = 1'b0;
      o_sda_low = 1'b1;
    end else if (bitc == 9) begin
      bitc = 0;
      tx = go;
      o_sda_low = 1'b0;
      if (go && !mack) begin
        tx_byte = ptr[7:0] ^ 8'ha5;
        ptr++;
        o_sda_low = !tx_byte[7];
      end
    end else if (tx && bitc > 0) begin
      o_sda_low = !tx_byte[7 - bitc];
    end
  end
endmodule

// File: sim/i2c_read_engine_test.sv
// Purpose: Self-checking bench of the bus read engine
// Assumes: Slave model on the far side, pull-ups on both lines
// Notes: ARRAY_LEN set to 2 to keep bus traffic short
`timescale 1ns/1ps
module i2c_read_engine_test;
  // ------------------------------------------------------------
  // Bench
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd = 1'b0;
  logic [7:0] ctrl = 8'h00;
  logic [1:0] am = 2'h0;
  logic [15:0] adr = 16'h0000;
  logic [1:0] kind = 2'h0;
  logic [7:0] cnt = 8'h00;
  logic lenmod = 1'b0;
  logic slow = 1'b0;
  logic drv = 1'b0;
  logic rdy = 1'b1;
  logic busy, done, nack, rd_valid, sda_out, sda_oe, scl_out, scl_oe, slv_low;
  logic [15:0] rd_data;
  logic [15:0] got[$];
  int bad_count = 0;
  int checks_done = 0;
  wire sda = !(sda_oe && !sda_out) && !slv_low;
  wire scl = scl_oe ? scl_out : 1'b1;
  always #2 clk = ~clk;
  i2c_read_engine #(.ARRAY_LEN(2), .FIFO_DEPTH(8)) dut (.i_clk_sys(clk), .i_rst(rst),
    .i_bus_read_command(cmd), .i_ctrl(ctrl), .i_addr_mode(am), .i_addr(adr),
    .i_item_kind(kind), .i_item_count(cnt), .i_array_length_modifier(lenmod),
    .i_slow_bus(slow), .i_drive_scl(drv), .o_busy(busy), .o_done(done), .o_nack(nack),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .i_rd_ready(rdy), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_scl(scl), .o_scl_out(scl_out),
    .o_scl_oe(scl_oe));
  i2c_slave_model slave (.i_scl(scl), .i_sda(sda), .o_sda_low(slv_low));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (!rst && sda_oe === 1'b1) begin
      chk("sda_out", 16'h0, 16'(sda_out));
    end
    if (!rst && !drv && scl_oe === 1'b1) begin
      chk("scl_out", 16'h0, 16'(scl_out));
    end
    if (!rst && drv && busy === 1'b1) begin
      chk("scl_oe", 16'h1, 16'(scl_oe));
    end
    if (!rst && rd_valid === 1'b1 && rdy) begin
      got.push_back(rd_data);
    end
  end
  task automatic run(input logic [7:0] c, input logic [1:0] m, input logic [15:0] a,
                     input logic [1:0] k, input logic lm, input logic d);
    int t;
    t = 0;
    slave.rx_log.delete();
    slave.ack_log.delete();
    slave.starts = 0;
    slave.stops = 0;
    got.delete();
    @(posedge clk);
    ctrl <= c;
    am <= m;
    adr <= a;
    kind <= k;
    cnt <= 8'h01;
    lenmod <= lm;
    drv <= d;
    cmd <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
    #1;
    chk("busy", 16'h1, 16'(busy));
    while (done !== 1'b1 && t < 45000) begin
      @(posedge clk);
      #1;
      t++;
    end
    chk("done", 16'h1, 16'(done));
    chk("sda_oe idle", 16'h0, 16'(sda_oe));
  endtask
  task automatic vfy(input string name, input logic [7:0] xr[$], input logic [15:0] xi[$],
                     input int xs, input int nb);
    repeat (8) @(posedge clk);
    chk("starts", 16'(xs), 16'(slave.starts));
    chk("stops", 16'h1, 16'(slave.stops));
    chk("bytes sent", 16'(xr.size()), 16'(slave.rx_log.size()));
    foreach (xr[i]) chk("byte sent", {8'h00, xr[i]}, {8'h00, slave.rx_log[i]});
    chk("items", 16'(xi.size()), 16'(got.size()));
    foreach (xi[i]) chk("item", xi[i], got[i]);
    chk("acks", 16'(nb), 16'(slave.ack_log.size()));
    for (int i = 0; i < nb; i++) chk("ack", 16'(i == nb - 1), 16'(slave.ack_log[i]));
    $display("Test %s done", name);
  endtask
  task automatic t_word();
    run(8'ha1, i2c_rd_pkg::ADDR_16, 16'h1234, i2c_rd_pkg::KIND_WORD, 1'b0, 1'b0);
    vfy("word", '{8'ha0, 8'h12, 8'h34, 8'ha1}, '{16'h9190}, 2, 2);
  endtask
  task automatic t_full_array();
    @(posedge clk);
    rdy <= 1'b0;
    run(8'ha0, i2c_rd_pkg::ADDR_NONE, 16'h0000, i2c_rd_pkg::KIND_ARRAY, 1'b0, 1'b0);
    chk("held valid", 16'h1, 16'(rd_valid));
    @(posedge clk);
    rdy <= 1'b1;
    vfy("full_array", '{8'ha1}, '{16'h0093, 16'h0092}, 1, 2);
  endtask
  task automatic t_bit_item();
    run(8'ha0, i2c_rd_pkg::ADDR_8, 16'hff40, i2c_rd_pkg::KIND_BIT, 1'b0, 1'b1);
    vfy("bit_item", '{8'ha0, 8'h40, 8'ha1}, '{16'h0001}, 2, 1);
  endtask
  task automatic t_count_array();
    run(8'ha1, i2c_rd_pkg::ADDR_NONE, 16'h0000, i2c_rd_pkg::KIND_ARRAY, 1'b1, 1'b0);
    vfy("count_array", '{8'ha1}, '{16'h00e4}, 1, 1);
  endtask
  task automatic t_byte_item();
    run(8'ha0, i2c_rd_pkg::ADDR_NONE, 16'h0000, i2c_rd_pkg::KIND_BYTE, 1'b0, 1'b0);
    vfy("byte_item", '{8'ha1}, '{16'h00e7}, 1, 1);
  endtask
  task automatic t_slow_rate();
    int n;
    n = 0;
    @(posedge clk);
    slow <= 1'b1;
    cmd <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
    while (scl !== 1'b0) @(posedge clk);
    while (scl !== 1'b1) @(posedge clk);
    while (scl !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    while (scl !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk("slow period", 16'h1, 16'(n >= 10000 / 4));
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("busy in reset", 16'h0, 16'(busy));
    rst <= 1'b0;
    $display("Test slow_rate done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_word();
    t_full_array();
    t_bit_item();
    t_count_array();
    t_byte_item();
    t_slow_rate();
    end_of_test();
  end
  initial begin
    #(4 * 150000);
    bad_count++;
    $display("FAIL watchdog expected finish seen hang");
    end_of_test();
  end
endmodule
